// ===== inc/position_range_defines.vh
// constants for the position scaling and range-mapping unit
`ifndef POSITION_RANGE_DEFINES_VH
`define POSITION_RANGE_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_REF_VALUE     8'h00
`define OFS_ACTUAL_POS    8'h04
`define OFS_TARGET_POS    8'h08
`define OFS_MAP_END       8'h0C
`define OFS_LOWER_LIMIT   8'h10
`define OFS_UPPER_LIMIT   8'h14
`define OFS_NUMERATOR     8'h18
`define OFS_DENOMINATOR   8'h1C
`define OFS_IRQ_STATUS    8'h20
`define OFS_IRQ_MASK      8'h24
`define OFS_STEPS_PER_ROT 8'h28
// ----------------------------------------
// factory default values
// ----------------------------------------
`define RST_MAP_END       32'h00019000
`define RST_LOWER_LIMIT   32'h000004B0
`define RST_UPPER_LIMIT   32'h00018B50
`define RST_ACTUAL_POS    32'h0000C800
`define RST_SCALE         32'h00000190
`define RST_MARGIN_LO     32'h000004B0
`define RST_MARGIN_HI     32'h00018B50
// ----------------------------------------
// scaling factors and rotation counts
// ----------------------------------------
`define K_ROT             32'h00000190
`define K_MARGIN_LO       32'h000004B0
`define K_MARGIN_HI       32'h00018B50
`define ROT_MARGIN        32'h00000003
`define ROT_LOWER         32'h000000FD
`define ROT_WINDOW        32'h00000100
`define SCALE_MIN         32'h00000001
`define SCALE_MAX         32'h00002710
// divider sequencing: one load cycle, then one cycle per quotient bit
`define DIV_LOAD          6'h21
`define DIV_STEPS         6'h20
// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define IRQ_TARGET_ERR    0
`define IRQ_PARAM_FAIL    1
`define IRQ_BITS          2
`endif

// ===== rtl/position_range_mapping.v
// position scaling and range-mapping unit with an AHB-Lite register slave
`timescale 1ns/1ps
`include "position_range_defines.vh"

//
// Behaviour
// - direct referencing write shifts all reported positions
// - actual write sets reference to value minus physical
// - reference change re-frames all reported positions
// - position count ignores motor supply loss
// - targets into end margins are rejected
// - defaults: mapping end 102400, limits 1200/101200
// - default actual position 51200
// - limits follow mapping end minus 253/3 rotations
// - accept mapping end only if actual within one step of the new limits
// - mapping end bounded by scaled 1200 and 101200
// - scaled bounds rounded to nearest integer
// - actual wrapped by one window into mapping span
// - steps per rotation is 400 times den/num
// - master may narrow limits inside derived range
// - numerator, denominator default 400, reference zero
module position_range_mapping (
    input  wire        hclk,            // system clock
    input  wire        hresetn,         // async reset, active low
    input  wire        hsel,            // slave select
    input  wire [31:0] haddr,           // byte address
    input  wire [1:0]  htrans,          // transfer type
    input  wire        hwrite,          // write when high
    input  wire [2:0]  hsize,           // transfer size, word only
    input  wire [31:0] hwdata,          // write data
    input  wire        hready,          // bus ready in
    output wire        hreadyout,       // slave ready out
    output wire        hresp,           // always okay
    output reg  [31:0] hrdata,          // read data
    input  wire        step_inc,        // one-step pulse upward
    input  wire        step_dec,        // one-step pulse downward
    output reg  [31:0] target_position, // accepted target, reported frame
    output reg         target_strobe,   // pulse on accepted target
    output wire        irq              // level interrupt
);

// ----------------------------------------
// state
// ----------------------------------------
reg signed [31:0] phys;          // physical position count
reg signed [31:0] ref_value;     // referencing value
reg signed [31:0] target_phys;   // target, physical frame
reg signed [31:0] map_end;       // upper mapping end, physical frame
reg signed [31:0] lower_limit;   // lower limit, physical frame
reg signed [31:0] upper_limit;   // upper limit, physical frame
reg        [31:0] numerator;     // scaling numerator
reg        [31:0] denominator;   // scaling denominator
reg        [31:0] rot_steps;     // steps per output rotation
reg        [31:0] margin_lo;     // scaled minimum mapping offset
reg        [31:0] margin_hi;     // scaled maximum mapping offset
reg [`IRQ_BITS-1:0] irq_status;  // sticky events
reg [`IRQ_BITS-1:0] irq_mask;    // event enables
reg         dp_write;            // data phase holds a write
reg  [7:0]  dp_addr;             // data phase address

// divider state
reg         div_busy;            // scaling quotients under way
reg  [1:0]  div_idx;             // which quotient is computed
reg  [5:0]  div_cnt;             // remaining iterations
reg  [31:0] div_rem;             // partial remainder
reg  [31:0] div_quo;             // quotient bits

// ----------------------------------------
// bus handshake and interrupt
// ----------------------------------------
// stalling all transfers while quotients settle keeps bounds coherent
assign hreadyout = ~div_busy;
assign hresp     = 1'b0;
assign irq       = |(irq_status & irq_mask);

wire addr_take = hsel & htrans[1] & hready;
wire wr_commit = dp_write & hreadyout;

// ----------------------------------------
// derived quantities
// ----------------------------------------
wire signed [31:0] rot_s     = rot_steps;
wire signed [31:0] window    = rot_s * `ROT_WINDOW;
wire signed [31:0] actual    = phys + ref_value;
wire signed [31:0] wdata_s   = hwdata;
wire signed [31:0] wphys     = wdata_s - ref_value;
// derived range of the present mapping end
wire signed [31:0] dlow_cur  = map_end - rot_s * `ROT_LOWER;
wire signed [31:0] dhigh_cur = map_end - rot_s * `ROT_MARGIN;
// candidate range for a new mapping end
wire signed [31:0] cand_low  = wphys - rot_s * `ROT_LOWER;
wire signed [31:0] cand_high = wphys - rot_s * `ROT_MARGIN;
wire signed [31:0] cand_bot  = wphys - window;
wire signed [31:0] ms_lo     = margin_lo;
wire signed [31:0] ms_hi     = margin_hi;

reg signed [31:0] cand_phys;
always @* begin
    cand_phys = phys;
    if (phys < cand_bot) begin
        cand_phys = phys + window;
    end else if (phys > wphys) begin
        cand_phys = phys - window;
    end
end

wire map_bounds_ok = (wphys >= phys + ms_lo) && (wphys <= phys + ms_hi);
wire map_in_range  = (cand_phys >= cand_low - 32'sd1) && (cand_phys <= cand_high + 32'sd1);
wire map_ok        = map_bounds_ok & map_in_range;

wire target_ok = (wphys >= lower_limit) && (wphys <= upper_limit);
wire lower_ok  = (wphys >= dlow_cur) && (wphys <= upper_limit);
wire upper_ok  = (wphys <= dhigh_cur) && (wphys >= lower_limit);
wire scale_ok  = (hwdata >= `SCALE_MIN) && (hwdata <= `SCALE_MAX);

// ----------------------------------------
// address phase capture and read data
// ----------------------------------------
// read data is latched at the address phase so it comes from a flop
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        dp_write <= 1'b0;
        dp_addr  <= 8'h00;
        hrdata   <= 32'h00000000;
    end else if (hreadyout) begin
        dp_write <= addr_take & hwrite;
        dp_addr  <= haddr[7:0];
        hrdata   <= 32'h00000000;
        if (addr_take & ~hwrite) begin
            case (haddr[7:0])
                `OFS_REF_VALUE:     hrdata <= ref_value;
                `OFS_ACTUAL_POS:    hrdata <= actual;
                `OFS_TARGET_POS:    hrdata <= target_phys + ref_value;
                `OFS_MAP_END:       hrdata <= map_end + ref_value;
                `OFS_LOWER_LIMIT:   hrdata <= lower_limit + ref_value;
                `OFS_UPPER_LIMIT:   hrdata <= upper_limit + ref_value;
                `OFS_NUMERATOR:     hrdata <= numerator;
                `OFS_DENOMINATOR:   hrdata <= denominator;
                `OFS_IRQ_STATUS:    hrdata <= {{(32-`IRQ_BITS){1'b0}}, irq_status};
                `OFS_IRQ_MASK:      hrdata <= {{(32-`IRQ_BITS){1'b0}}, irq_mask};
                `OFS_STEPS_PER_ROT: hrdata <= rot_steps;
                default:            hrdata <= 32'h00000000;
            endcase
        end
    end
end

// ----------------------------------------
// positions, limits and scaling registers
// ----------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        phys          <= `RST_ACTUAL_POS;
        ref_value     <= 32'h00000000;
        numerator     <= `RST_SCALE;
        denominator   <= `RST_SCALE;
        map_end       <= `RST_MAP_END;
        lower_limit   <= `RST_LOWER_LIMIT;
        upper_limit   <= `RST_UPPER_LIMIT;
        target_phys   <= `RST_ACTUAL_POS;
        target_strobe <= 1'b0;
        irq_mask      <= {`IRQ_BITS{1'b0}};
    end else begin
        target_strobe <= 1'b0;
        if (step_inc & ~step_dec) begin
            phys <= phys + 32'sd1;
        end else if (step_dec & ~step_inc) begin
            phys <= phys - 32'sd1;
        end
        if (wr_commit) begin
            case (dp_addr)
                `OFS_REF_VALUE:  ref_value <= hwdata;
                `OFS_ACTUAL_POS: ref_value <= wdata_s - phys;
                `OFS_TARGET_POS: begin
                    if (target_ok) begin
                        target_phys   <= wphys;
                        target_strobe <= 1'b1;
                    end
                end
                `OFS_MAP_END: begin
                    if (map_ok) begin
                        map_end     <= wphys;
                        lower_limit <= cand_low;
                        upper_limit <= cand_high;
                        phys        <= cand_phys;
                    end
                end
                `OFS_LOWER_LIMIT: begin
                    if (lower_ok) begin
                        lower_limit <= wphys;
                    end
                end
                `OFS_UPPER_LIMIT: begin
                    if (upper_ok) begin
                        upper_limit <= wphys;
                    end
                end
                `OFS_NUMERATOR: begin
                    if (scale_ok) begin
                        numerator <= hwdata;
                    end
                end
                `OFS_DENOMINATOR: begin
                    if (scale_ok) begin
                        denominator <= hwdata;
                    end
                end
                `OFS_IRQ_MASK: irq_mask <= hwdata[`IRQ_BITS-1:0];
                default: begin
                end
            endcase
        end
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        target_position <= `RST_ACTUAL_POS;
    end else begin
        // output follows the reported frame, so it tracks reference changes
        target_position <= target_phys + ref_value;
    end
end

// ----------------------------------------
// sticky interrupt status
// ----------------------------------------
wire target_rej = wr_commit && (dp_addr == `OFS_TARGET_POS) && !target_ok;
wire param_rej  = wr_commit && (((dp_addr == `OFS_MAP_END) && !map_ok) ||
                                ((dp_addr == `OFS_LOWER_LIMIT) && !lower_ok) ||
                                ((dp_addr == `OFS_UPPER_LIMIT) && !upper_ok) ||
                                ((dp_addr == `OFS_NUMERATOR) && !scale_ok) ||
                                ((dp_addr == `OFS_DENOMINATOR) && !scale_ok));
wire [`IRQ_BITS-1:0] irq_set = {param_rej, target_rej};
wire [`IRQ_BITS-1:0] irq_clr = (wr_commit && (dp_addr == `OFS_IRQ_STATUS)) ?
                               hwdata[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}};

// set beats write-one-to-clear in the same cycle
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        irq_status <= {`IRQ_BITS{1'b0}};
    end else begin
        irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
end

// ----------------------------------------
// scaling divider
// ----------------------------------------
// one restoring divider serves three quotients in turn: area over speed
wire        scale_wr  = wr_commit && scale_ok &&
                        ((dp_addr == `OFS_NUMERATOR) || (dp_addr == `OFS_DENOMINATOR));
reg  [31:0] div_k;               // scale constant of current quotient
reg  [31:0] div_num;             // rounded dividend
always @* begin
    case (div_idx)
        2'd0:    div_k = `K_ROT;
        2'd1:    div_k = `K_MARGIN_LO;
        default: div_k = `K_MARGIN_HI;
    endcase
    div_num = div_k * denominator + {1'b0, numerator[31:1]};
end

wire [32:0] div_trial = {div_rem, div_quo[31]} - {1'b0, numerator};

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        div_busy  <= 1'b0;
        div_idx   <= 2'd0;
        div_cnt   <= 6'd0;
        div_rem   <= 32'h00000000;
        div_quo   <= 32'h00000000;
        rot_steps <= `RST_SCALE;
        margin_lo <= `RST_MARGIN_LO;
        margin_hi <= `RST_MARGIN_HI;
    end else if (!div_busy) begin
        if (scale_wr) begin
            div_busy <= 1'b1;
            div_idx  <= 2'd0;
            div_cnt  <= `DIV_LOAD;
        end
    end else if (div_cnt == `DIV_LOAD) begin
        // load dividend for the selected quotient
        div_rem <= 32'h00000000;
        div_quo <= div_num;
        div_cnt <= `DIV_STEPS;
    end else if (div_cnt != 6'd0) begin
        if (!div_trial[32]) begin
            div_rem <= div_trial[31:0];
            div_quo <= {div_quo[30:0], 1'b1};
        end else begin
            div_rem <= {div_rem[30:0], div_quo[31]};
            div_quo <= {div_quo[30:0], 1'b0};
        end
        div_cnt <= div_cnt - 6'd1;
    end else begin
        case (div_idx)
            2'd0:    rot_steps <= div_quo;
            2'd1:    margin_lo <= div_quo;
            default: margin_hi <= div_quo;
        endcase
        if (div_idx == 2'd2) begin
            div_busy <= 1'b0;
        end else begin
            div_idx <= div_idx + 2'd1;
            div_cnt <= `DIV_LOAD;
        end
    end
end

endmodule // position_range_mapping

// ===== verification/step_source.sv
// encoder model that pulses the physical step count up or down
`timescale 1ns/1ps
module step_source (
    input  wire hclk,     // system clock
    output reg  step_inc, // one-step pulse upward
    output reg  step_dec  // one-step pulse downward
);
    initial begin
        step_inc = 1'b0;
        step_dec = 1'b0;
    end
    // one-cycle pulses with a gap; slow leaves extra idle cycles
    task automatic run(input int n, input bit up, input bit slow);
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            step_inc <= up;
            step_dec <= !up;
            @(posedge hclk);
            step_inc <= 1'b0;
            step_dec <= 1'b0;
            if (slow) repeat (3) @(posedge hclk);
        end
    endtask
endmodule // step_source

// ===== verification/range_checker_assertions.sv
// port-level assertions for the range-mapping unit
`timescale 1ns/1ps
module range_checker (
    input wire        hclk,            // system clock
    input wire        hresetn,         // async reset, active low
    input wire        hsel,            // slave select
    input wire [31:0] haddr,           // byte address
    input wire [1:0]  htrans,          // transfer type
    input wire        hwrite,          // write when high
    input wire [31:0] hwdata,          // write data, data phase
    input wire        hready,          // bus ready in
    input wire        hreadyout,       // slave ready out
    input wire [31:0] hrdata,          // read data
    input wire [31:0] target_position, // accepted target
    input wire        target_strobe,   // accepted target pulse
    input wire        irq              // level interrupt
);
    reg        dp_on;                            // a data phase is open
    reg        dp_wr;                            // that phase writes
    reg  [7:0] dp_ad;                            // its offset
    wire       wr_done = dp_on & hreadyout & dp_wr; // write commits now
    wire       tgt_done = wr_done & (dp_ad == 8'h08);
    // only a scale value in range starts the divider; a refused one must not stall
    wire       sc_ok = (hwdata >= 32'h00000001) && (hwdata <= 32'h00002710);
    wire       sc_done = wr_done & (dp_ad == 8'h18 || dp_ad == 8'h1C) & sc_ok;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // track the data phase; a stalled slave keeps it open
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_on <= 1'b0;
            dp_wr <= 1'b0;
            dp_ad <= 8'h00;
        end else if (hready) begin
            dp_on <= hsel & htrans[1];
            dp_wr <= hwrite;
            dp_ad <= haddr[7:0];
        end
    end
    sequence scale_write;
        sc_done;
    endsequence
    sequence divider_busy;
        !hreadyout [*8];
    endsequence
    strobe_single_a: assert property (target_strobe |=> !target_strobe)
        else $error("target strobe longer than one cycle");
    strobe_cause_a: assert property (target_strobe |-> $past(tgt_done) || $past(tgt_done, 2))
        else $error("target strobe without a target write");
    rdata_quiet_a: assert property ((!dp_on || dp_wr) |-> hrdata == 32'h00000000)
        else $error("read data outside a read phase");
    unmapped_zero_a: assert property (dp_on && !dp_wr && dp_ad > 8'h28 |-> hrdata == 32'h00000000)
        else $error("unmapped read not zero");
    stall_bound_a: assert property ($fell(hreadyout) |-> ##[1:120] hreadyout)
        else $error("divider stall too long");
    stall_cause_a: assert property ($fell(hreadyout) |-> $past(sc_done) || $past(sc_done, 2))
        else $error("stall without a scale write");
    scale_stall_a: assert property (scale_write |=> divider_busy)
        else $error("scale write did not stall the bus");
    irq_cause_a: assert property ($changed(irq) |-> $past(wr_done))
        else $error("interrupt moved without a write");
    tpos_cause_a: assert property (!$stable(target_position) |-> $past(wr_done) || $past(wr_done, 2)
        || $past(wr_done, 3))
        else $error("target position moved without a write");
endmodule // range_checker
bind position_range_mapping range_checker chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .target_position(target_position), .target_strobe(target_strobe), .irq(irq));

// ===== verification/testbench.sv
// self-checking bench for the range-mapping unit with a reference model
`timescale 1ns/1ps
`include "position_range_defines.vh"
module testbench;
    logic        hclk;            // system clock
    logic        hresetn;         // reset, active low
    logic        hsel;            // slave select
    logic        hwrite;          // write when high
    logic [1:0]  htrans;          // transfer type
    logic [31:0] haddr;           // byte address
    logic [31:0] hwdata;          // write data
    logic [31:0] rng = 32'd88;    // xorshift state
    wire         hreadyout;       // slave ready, also bus ready
    wire         hresp;           // response, checked to be okay
    wire  [31:0] hrdata;          // read data
    wire         step_inc;        // encoder pulse up
    wire         step_dec;        // encoder pulse down
    wire  [31:0] target_position; // accepted target
    wire         target_strobe;   // accepted target pulse
    wire         irq;             // level interrupt
    int fail_count = 0, n_compared = 0, cycles = 0, strobes = 0, accepted = 0, k;
    // model state, positions in the physical frame
    int phys = 51200, rf = 0, tgt = 51200, me = 102400, lo = 1200, hi = 101200;
    int num = 400, den = 400, rot = 400, mlo = 1200, mhi = 101200, st = 0, mk = 0;
    position_range_mapping dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .step_inc(step_inc), .step_dec(step_dec),
        .target_position(target_position), .target_strobe(target_strobe), .irq(irq));
    step_source enc (.hclk(hclk), .step_inc(step_inc), .step_dec(step_dec));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // cycle ceiling cuts a hang short; strobes are counted for the model
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (target_strobe === 1'b1) strobes <= strobes + 1;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish;
        end
    end
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // reference model of one write: accepted or refused with a status bit
    task automatic mwrite(input int a, input int v);
        int p = v - rf;
        int ph = phys;
        case (a)
            `OFS_REF_VALUE: rf = v;
            `OFS_ACTUAL_POS: rf = v - phys;
            `OFS_TARGET_POS: if (p >= lo && p <= hi) begin
                tgt = p;
                accepted++;
            end else st |= 1;
            `OFS_MAP_END: begin
                if (ph < p - 256 * rot) ph += 256 * rot;
                if (ph > p) ph -= 256 * rot;
                if (v >= phys + rf + mlo && v <= phys + rf + mhi && ph >= p - 253 * rot - 1
                    && ph <= p - 3 * rot + 1) begin
                    me = p;
                    lo = p - 253 * rot;
                    hi = p - 3 * rot;
                    phys = ph;
                end else st |= 2;
            end
            `OFS_LOWER_LIMIT: if (p >= me - 253 * rot && p <= hi) lo = p; else st |= 2;
            `OFS_UPPER_LIMIT: if (p >= lo && p <= me - 3 * rot) hi = p; else st |= 2;
            `OFS_NUMERATOR, `OFS_DENOMINATOR: if (v < 1 || v > 10000) st |= 2; else begin
                if (a == `OFS_NUMERATOR) num = v; else den = v;
                rot = (400 * den + num / 2) / num;
                mlo = (1200 * den + num / 2) / num;
                mhi = (101200 * den + num / 2) / num;
            end
            `OFS_IRQ_STATUS: st &= ~v;
            `OFS_IRQ_MASK: mk = v & 3;
            default: ;
        endcase
    endtask
    function automatic int mread(input int a);
        case (a)
            `OFS_REF_VALUE: return rf;
            `OFS_ACTUAL_POS: return phys + rf;
            `OFS_TARGET_POS: return tgt + rf;
            `OFS_MAP_END: return me + rf;
            `OFS_LOWER_LIMIT: return lo + rf;
            `OFS_UPPER_LIMIT: return hi + rf;
            `OFS_NUMERATOR: return num;
            `OFS_DENOMINATOR: return den;
            `OFS_IRQ_STATUS: return st;
            `OFS_IRQ_MASK: return mk;
            `OFS_STEPS_PER_ROT: return rot;
            default: return 0;
        endcase
    endfunction
    // one single AHB-Lite transfer; the master waits for ready in both phases
    task automatic bus(input bit w, input int a, input int d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %0d seen %0d", what, $signed(exp), $signed(got));
        end
    endtask
    task automatic wr(input int a, input int v);
        logic [31:0] r;
        bus(1'b1, a, v, r);
        mwrite(a, v);
    endtask
    // every register, one unmapped offset, and the side outputs
    task automatic check_all;
        logic [31:0] r;
        for (int a = 0; a <= 'h2C; a += 4) begin
            bus(1'b0, a, 0, r);
            cmp($sformatf("reg %h", a), mread(a), r);
        end
        cmp("irq", 32'(|(st & mk)), 32'(irq));
        cmp("target_position", tgt + rf, target_position);
        cmp("strobes", accepted, strobes);
        cmp("hresp", 32'h00000000, 32'(hresp));
    endtask
    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 0;
        hwdata = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        check_all;
        // encoder moves the count, fast then slow
        k = int'(rnd() % 20) + 1;
        enc.run(k, 1'b1, 1'b0);
        phys += k;
        k = int'(rnd() % 7) + 1;
        enc.run(k, 1'b0, 1'b1);
        phys -= k;
        wr(`OFS_REF_VALUE, int'(rnd() % 4096) - 2048);
        check_all;
        wr(`OFS_ACTUAL_POS, int'(rnd() % 100000));
        check_all;
        wr(`OFS_TARGET_POS, lo + rf);
        wr(`OFS_TARGET_POS, hi + rf + 1);
        check_all;
        wr(`OFS_IRQ_MASK, 3);
        check_all;
        wr(`OFS_IRQ_STATUS, 1);
        wr(`OFS_MAP_END, phys + rf + mhi + 1);
        wr(`OFS_MAP_END, phys + rf + mhi);
        check_all;
        wr(`OFS_MAP_END, phys + rf + mlo);
        wr(`OFS_LOWER_LIMIT, lo + rf + 100);
        wr(`OFS_UPPER_LIMIT, hi + rf + 1);
        wr(`OFS_LOWER_LIMIT, me - 253 * rot + rf - 1);
        wr(`OFS_UPPER_LIMIT, hi + rf - 50);
        check_all;
        wr(`OFS_IRQ_STATUS, 3);
        wr(`OFS_NUMERATOR, 0);
        wr(`OFS_NUMERATOR, 7);
        wr(`OFS_DENOMINATOR, 2);
        wr(`OFS_DENOMINATOR, 10001);
        check_all;
        wr(`OFS_MAP_END, phys + rf + mlo - 1);
        wr(`OFS_MAP_END, phys + rf + mlo);
        wr(`OFS_TARGET_POS, lo + rf + int'(rnd() % 64));
        check_all;
        tally_and_finish;
    end
endmodule // testbench
